// >>> pcla_top.sv
`timescale 1ns/100ps
// What this block does
// - port reference: 10 rx framer, 11 tx framer
// - timer reference: global at 0, port at 1
// - loop timing sends receive clock to transmit
// - rate adapter clock unless control bit set
// - rx framer pins timing select bit
// - tx framer pins timing select bit
// - tx line pins timing select bit
// - loopback codes 000 to 011 decoded
// - codes 1xx diagnostic, 110 adds line
// - upper alarm field drives second pin
// - lower alarm field drives first pin
// - alarm codes 0000-0101 select single alarm
// - combined alarm codes, others select nothing
// - transmit inversion register, one bit per pin
// - set inversion bit flips pin polarity
module pcla_top #(
    parameter int unsigned HADDR_W = 32
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic hsel_i,
    input wire logic [HADDR_W-1:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    input wire logic global_ref_8k_i,
    input wire logic rx_framer_ref_8k_i,
    input wire logic tx_framer_ref_8k_i,
    output logic port_ref_o,
    output logic second_timer_ref_o,
    input wire logic rx_clk_i,
    input wire logic rate_adapter_clk_i,
    output logic tx_clk_o,
    output pcla_pkg::pcla_tx_clk_src_t tx_clk_src_o,
    output logic rx_framer_timing_sel_o,
    output logic tx_framer_timing_sel_o,
    output logic tx_line_timing_sel_o,
    output logic analog_loop_o,
    output logic line_loop_o,
    output logic payload_loop_o,
    output logic diagnostic_loop_o,
    input wire logic [pcla_pkg::ALM_N-1:0] alarm_i,
    input wire logic first_pin_out_en_i,
    input wire logic second_pin_out_en_i,
    output logic first_general_pin_o,
    output logic first_general_pin_oe_o,
    output logic second_general_pin_o,
    output logic second_general_pin_oe_o,
    input wire logic [pcla_pkg::REG_W-1:0] tx_pin_core_i,
    output logic [pcla_pkg::REG_W-1:0] tx_pin_o
);
    import pcla_pkg::*;

    if (HADDR_W < 10 || HADDR_W > 32)
    begin : g_bad_addr_w
        $error("HADDR_W must lie between 10 and 32");
    end

    // ---------------- bus slave and registers ----------------
    logic wr_pend_ff, nxt_wr_pend;
    logic [HADDR_W-1:0] addr_ff, nxt_addr;
    logic [15:0] clk_timing_ff, nxt_clk_timing;
    logic [15:0] loop_alarm_ff, nxt_loop_alarm;
    logic [15:0] tx_inv_ff, nxt_tx_inv;
    logic [31:0] rdata_ff, nxt_rdata;
    logic addr_phase;

    function automatic logic [15:0] read_word(
        input logic [HADDR_W-1:0] a,
        input logic [15:0] r_clk,
        input logic [15:0] r_loop,
        input logic [15:0] r_inv
    );
        logic [15:0] w;
        w = 16'h0000;
        if (a == ADDR_CLK_TIMING[HADDR_W-1:0])
            w = r_clk;
        else if (a == ADDR_LOOP_ALARM[HADDR_W-1:0])
            w = r_loop;
        else if (a == ADDR_TX_INV[HADDR_W-1:0])
            w = r_inv;
        return w;
    endfunction

    // only whole-word transfers reach the registers; others are ignored
    assign addr_phase = hsel_i && hready_i && htrans_i[1]
                        && (hsize_i == 3'h2);

    always_comb
    begin
        nxt_wr_pend = addr_phase && hwrite_i;
        nxt_addr = addr_phase ? haddr_i : addr_ff;
        nxt_clk_timing = clk_timing_ff;
        nxt_loop_alarm = loop_alarm_ff;
        nxt_tx_inv = tx_inv_ff;
        if (wr_pend_ff)
        begin
            if (addr_ff == ADDR_CLK_TIMING[HADDR_W-1:0])
                nxt_clk_timing = hwdata_i[15:0] & MASK_CLK_TIMING;
            if (addr_ff == ADDR_LOOP_ALARM[HADDR_W-1:0])
                nxt_loop_alarm = hwdata_i[15:0] & MASK_LOOP_ALARM;
            if (addr_ff == ADDR_TX_INV[HADDR_W-1:0])
                nxt_tx_inv = hwdata_i[15:0] & MASK_TX_INV;
        end
        // read from next values so a read right behind a write sees it
        nxt_rdata = rdata_ff;
        if (addr_phase && !hwrite_i)
            nxt_rdata = {16'h0000, read_word(haddr_i, nxt_clk_timing,
                                             nxt_loop_alarm, nxt_tx_inv)};
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wr_pend_ff <= 1'b0;
            addr_ff <= '0;
            clk_timing_ff <= RST_CLK_TIMING;
            loop_alarm_ff <= RST_LOOP_ALARM;
            tx_inv_ff <= RST_TX_INV;
            rdata_ff <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_ff <= nxt_wr_pend;
            addr_ff <= nxt_addr;
            clk_timing_ff <= nxt_clk_timing;
            loop_alarm_ff <= nxt_loop_alarm;
            tx_inv_ff <= nxt_tx_inv;
            rdata_ff <= nxt_rdata;
        end
    end

    // zero wait states, always OKAY
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = rdata_ff;

    // ---------------- port functions ----------------
    logic [1:0] port_ref_code;
    logic [2:0] lb_code;
    logic [15:0] tx_pin_adj;
    logic first_alarm, second_alarm;
    logic port_ref_ff, nxt_port_ref;
    logic timer_ref_ff, nxt_timer_ref;
    pcla_tx_clk_src_t tx_src_ff, nxt_tx_src;
    logic tx_clk_ff, nxt_tx_clk;
    logic [3:0] lb_ff, nxt_lb;
    logic first_pin_ff, nxt_first_pin;
    logic second_pin_ff, nxt_second_pin;
    logic [15:0] tx_pin_ff;

    assign port_ref_code = clk_timing_ff[PORT_REF_LSB +: 2];
    assign lb_code = loop_alarm_ff[LOOPBACK_LSB +: 3];

    pcla_alarm_sel u_first_sel (
        .code_i(loop_alarm_ff[FIRST_ALARM_LSB +: 4]),
        .alarm_i(alarm_i),
        .sel_o(first_alarm)
    );

    pcla_alarm_sel u_second_sel (
        .code_i(loop_alarm_ff[SECOND_ALARM_LSB +: 4]),
        .alarm_i(alarm_i),
        .sel_o(second_alarm)
    );

    // per-pin polarity; reserved positions never invert
    for (genvar i = 0; i < REG_W; i++)
    begin : g_inv
        assign tx_pin_adj[i] = tx_pin_core_i[i]
                               ^ (tx_inv_ff[i] & MASK_TX_INV[i]);
    end

    always_comb
    begin
        // undefined 0x codes hold the port reference low
        unique case (port_ref_code)
            PORT_REF_RX: nxt_port_ref = rx_framer_ref_8k_i;
            PORT_REF_TX: nxt_port_ref = tx_framer_ref_8k_i;
            default: nxt_port_ref = 1'b0;
        endcase
        nxt_timer_ref = clk_timing_ff[TIMER_REF_SEL_BIT]
                        ? nxt_port_ref : global_ref_8k_i;
        unique case (lb_code) // {analog, line, payload, diagnostic}
            LB_NONE: nxt_lb = 4'h0;
            LB_ANALOG: nxt_lb = 4'h8;
            LB_LINE: nxt_lb = 4'h4;
            LB_PAYLOAD: nxt_lb = 4'h2;
            LB_LINE_DIAG: nxt_lb = 4'h5;
            default: nxt_lb = 4'h1;
        endcase
        if (clk_timing_ff[LOOP_TIMING_BIT])
            nxt_tx_src = TXC_RX;
        else if (!clk_timing_ff[RA_TX_CLK_CTRL_BIT])
            nxt_tx_src = TXC_RATE_ADAPTER;
        else if (nxt_lb != 4'h0)
            nxt_tx_src = TXC_RX;
        else
            nxt_tx_src = TXC_PIN;
        // the input pin is ignored unless it is the chosen source
        unique case (nxt_tx_src)
            TXC_RX: nxt_tx_clk = rx_clk_i;
            TXC_RATE_ADAPTER: nxt_tx_clk = rate_adapter_clk_i;
            TXC_PIN: nxt_tx_clk = tx_pin_adj[INV_TX_CLOCK_IN_BIT];
            default: nxt_tx_clk = 1'b0;
        endcase
        nxt_first_pin = first_alarm;
        nxt_second_pin = second_alarm;
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            port_ref_ff <= 1'b0;
            timer_ref_ff <= 1'b0;
            tx_src_ff <= TXC_RATE_ADAPTER;
            tx_clk_ff <= 1'b0;
            lb_ff <= 4'h0;
            first_pin_ff <= 1'b0;
            second_pin_ff <= 1'b0;
            tx_pin_ff <= 16'h0000;
        end
        else
        begin
            port_ref_ff <= nxt_port_ref;
            timer_ref_ff <= nxt_timer_ref;
            tx_src_ff <= nxt_tx_src;
            tx_clk_ff <= nxt_tx_clk;
            lb_ff <= nxt_lb;
            first_pin_ff <= nxt_first_pin;
            second_pin_ff <= nxt_second_pin;
            tx_pin_ff <= tx_pin_adj;
        end
    end

    assign port_ref_o = port_ref_ff;
    assign second_timer_ref_o = timer_ref_ff;
    assign tx_clk_src_o = tx_src_ff;
    assign tx_clk_o = tx_clk_ff;
    assign rx_framer_timing_sel_o = clk_timing_ff[RX_FRAMER_TIMING_BIT];
    assign tx_framer_timing_sel_o = clk_timing_ff[TX_FRAMER_TIMING_BIT];
    assign tx_line_timing_sel_o = clk_timing_ff[TX_LINE_TIMING_BIT];
    assign analog_loop_o = lb_ff[3];
    assign line_loop_o = lb_ff[2];
    assign payload_loop_o = lb_ff[1];
    assign diagnostic_loop_o = lb_ff[0];
    // pin enables belong to the global pin control outside this port
    assign first_general_pin_o = first_pin_ff;
    assign first_general_pin_oe_o = first_pin_out_en_i;
    assign second_general_pin_o = second_pin_ff;
    assign second_general_pin_oe_o = second_pin_out_en_i;
    assign tx_pin_o = tx_pin_ff;

    // ---------------- assertions ----------------
    property p_port_ref_rx;
        @(posedge clk_i) disable iff (!reset_n_i)
        (port_ref_code == PORT_REF_RX)
            |=> (port_ref_o == $past(rx_framer_ref_8k_i));
    endproperty
    a_port_ref_rx: assert property (p_port_ref_rx)
        else $error("port reference does not follow rx framer");
    property p_timer_ref_global;
        @(posedge clk_i) disable iff (!reset_n_i)
        !clk_timing_ff[TIMER_REF_SEL_BIT]
            |=> (second_timer_ref_o == $past(global_ref_8k_i));
    endproperty
    a_timer_ref_global: assert property (p_timer_ref_global)
        else $error("timer reference not taken from global source");
    property p_loop_timing;
        @(posedge clk_i) disable iff (!reset_n_i)
        clk_timing_ff[LOOP_TIMING_BIT]
            |=> (tx_clk_src_o == TXC_RX) && (tx_clk_o == $past(rx_clk_i));
    endproperty
    a_loop_timing: assert property (p_loop_timing)
        else $error("loop timing did not use receive clock");
    property p_pin_source;
        @(posedge clk_i) disable iff (!reset_n_i)
        (clk_timing_ff[4:3] == 2'h1) && (lb_code == LB_NONE)
            |=> (tx_clk_src_o == TXC_PIN);
    endproperty
    a_pin_source: assert property (p_pin_source)
        else $error("transmit clock pin not chosen");
    property p_line_diag;
        @(posedge clk_i) disable iff (!reset_n_i)
        (lb_code == LB_LINE_DIAG) |=> line_loop_o && diagnostic_loop_o
            && !analog_loop_o && !payload_loop_o;
    endproperty
    a_line_diag: assert property (p_line_diag)
        else $error("code 110 loopback decode wrong");
    property p_no_loop;
        @(posedge clk_i) disable iff (!reset_n_i)
        (lb_code == LB_NONE) |=> !analog_loop_o && !line_loop_o
            && !payload_loop_o && !diagnostic_loop_o;
    endproperty
    a_no_loop: assert property (p_no_loop)
        else $error("loopback active at code 000");
    property p_all_alarms;
        @(posedge clk_i) disable iff (!reset_n_i)
        (loop_alarm_ff[FIRST_ALARM_LSB +: 4] == 4'hF)
            |=> (first_general_pin_o == (|$past(alarm_i)));
    endproperty
    a_all_alarms: assert property (p_all_alarms)
        else $error("code 1111 did not combine all alarms");
    property p_inversion;
        @(posedge clk_i) disable iff (!reset_n_i)
        1'b1 |=> (tx_pin_o == ($past(tx_pin_core_i)
                               ^ ($past(tx_inv_ff) & MASK_TX_INV)));
    endproperty
    a_inversion: assert property (p_inversion)
        else $error("transmit pin polarity wrong");
    property p_inv_write;
        @(posedge clk_i) disable iff (!reset_n_i)
        (addr_phase && hwrite_i
            && haddr_i == ADDR_TX_INV[HADDR_W-1:0])
            |=> ##1 (tx_inv_ff == (16'($past(hwdata_i)) & MASK_TX_INV));
    endproperty
    a_inv_write: assert property (p_inv_write)
        else $error("inversion register write lost");
    // bit 12 is live only in the inversion register
    property p_reserved_zero;
        @(posedge clk_i) disable iff (!reset_n_i)
        (addr_phase && !hwrite_i) |=> (hrdata_o[31:16] == '0)
            && (($past(haddr_i) != ADDR_TX_INV[HADDR_W-1:0])
                || ((hrdata_o[15:0] & ~MASK_TX_INV) == '0))
            && (($past(haddr_i) == ADDR_TX_INV[HADDR_W-1:0])
                || (hrdata_o[15:11] == '0));
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved read bits not zero");

endmodule

// >>> pcla_pkg.sv
package pcla_pkg;

    localparam int unsigned REG_W = 16;

    // printed offsets are register indices; byte address is four times that
    localparam logic [7:0] IDX_CLK_TIMING = 8'h44;
    localparam logic [7:0] IDX_LOOP_ALARM = 8'h46;
    localparam logic [7:0] IDX_TX_INV = 8'h4A;
    localparam logic [31:0] ADDR_CLK_TIMING = 32'(IDX_CLK_TIMING) << 2;
    localparam logic [31:0] ADDR_LOOP_ALARM = 32'(IDX_LOOP_ALARM) << 2;
    localparam logic [31:0] ADDR_TX_INV = 32'(IDX_TX_INV) << 2;

    localparam logic [15:0] RST_CLK_TIMING = 16'h0000;
    localparam logic [15:0] RST_LOOP_ALARM = 16'h0000;
    localparam logic [15:0] RST_TX_INV = 16'h0000;
    localparam logic [15:0] MASK_CLK_TIMING = 16'h00FF;
    localparam logic [15:0] MASK_LOOP_ALARM = 16'h07FF;
    localparam logic [15:0] MASK_TX_INV = 16'h17FF;

    // clock and timing control fields
    localparam int unsigned TX_LINE_TIMING_BIT = 0;
    localparam int unsigned TX_FRAMER_TIMING_BIT = 1;
    localparam int unsigned RX_FRAMER_TIMING_BIT = 2;
    localparam int unsigned RA_TX_CLK_CTRL_BIT = 3;
    localparam int unsigned LOOP_TIMING_BIT = 4;
    localparam int unsigned TIMER_REF_SEL_BIT = 5;
    localparam int unsigned PORT_REF_LSB = 6;

    // loopback and alarm select fields
    localparam int unsigned FIRST_ALARM_LSB = 0;
    localparam int unsigned SECOND_ALARM_LSB = 4;
    localparam int unsigned LOOPBACK_LSB = 8;

    localparam logic [1:0] PORT_REF_RX = 2'h2;
    localparam logic [1:0] PORT_REF_TX = 2'h3;

    localparam logic [2:0] LB_NONE = 3'h0;
    localparam logic [2:0] LB_ANALOG = 3'h1;
    localparam logic [2:0] LB_LINE = 3'h2;
    localparam logic [2:0] LB_PAYLOAD = 3'h3;
    localparam logic [2:0] LB_LINE_DIAG = 3'h6;

    // alarm vector positions
    localparam int unsigned ALM_LOS = 0;
    localparam int unsigned ALM_OOF = 1;
    localparam int unsigned ALM_LOF = 2;
    localparam int unsigned ALM_AIS = 3;
    localparam int unsigned ALM_RAI = 4;
    localparam int unsigned ALM_IDLE = 5;
    localparam int unsigned ALM_N = 6;

    localparam int unsigned INV_TX_CLOCK_IN_BIT = 0;

    typedef enum logic [1:0] {
        TXC_PIN,
        TXC_RX,
        TXC_RATE_ADAPTER
    } pcla_tx_clk_src_t;

endpackage

// >>> pcla_alarm_sel.sv
`timescale 1ns/100ps
module pcla_alarm_sel
    import pcla_pkg::*;
(
    input wire logic [3:0] code_i,
    input wire logic [ALM_N-1:0] alarm_i,
    output logic sel_o
);

    always_comb
    begin
        unique case (code_i)
            4'h0: sel_o = alarm_i[ALM_LOS];
            4'h1: sel_o = alarm_i[ALM_OOF];
            4'h2: sel_o = alarm_i[ALM_LOF];
            4'h3: sel_o = alarm_i[ALM_AIS];
            4'h4: sel_o = alarm_i[ALM_RAI];
            4'h5: sel_o = alarm_i[ALM_IDLE];
            4'hB, 4'hD: sel_o = alarm_i[ALM_LOS] | alarm_i[ALM_LOF]
                              | alarm_i[ALM_AIS];
            4'hE: sel_o = alarm_i[ALM_RAI] | alarm_i[ALM_IDLE];
            4'hF: sel_o = |alarm_i;
            // remaining codes select no alarm
            default: sel_o = 1'b0;
        endcase
    end

endmodule

// >>> pcla_top_tb.sv
`timescale 1ns/100ps
module pcla_top_tb;
    import pcla_pkg::*;
    logic clk_i, reset_n_i, hsel_i, hwrite_i, hready_i, hreadyout_o;
    logic hresp_o, global_ref_8k_i, rx_framer_ref_8k_i, tx_framer_ref_8k_i;
    logic port_ref_o, second_timer_ref_o, rx_clk_i, rate_adapter_clk_i;
    logic tx_clk_o, rx_framer_timing_sel_o, tx_framer_timing_sel_o;
    logic tx_line_timing_sel_o, analog_loop_o, line_loop_o, payload_loop_o;
    logic diagnostic_loop_o, first_pin_out_en_i, second_pin_out_en_i;
    logic first_general_pin_o, first_general_pin_oe_o;
    logic second_general_pin_o, second_general_pin_oe_o;
    logic [1:0] htrans_i;
    logic [2:0] hsize_i;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
    logic [ALM_N-1:0] alarm_i;
    logic [REG_W-1:0] tx_pin_core_i, tx_pin_o;
    pcla_tx_clk_src_t tx_clk_src_o;
    int fails;
    int tests_run;

    // the lone slave's ready is the bus ready
    assign hready_i = hreadyout_o;

    pcla_top dut (
        .clk_i, .reset_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
        .hsize_i, .hwdata_i, .hready_i, .hreadyout_o, .hresp_o, .hrdata_o,
        .global_ref_8k_i, .rx_framer_ref_8k_i, .tx_framer_ref_8k_i,
        .port_ref_o, .second_timer_ref_o, .rx_clk_i, .rate_adapter_clk_i,
        .tx_clk_o, .tx_clk_src_o, .rx_framer_timing_sel_o,
        .tx_framer_timing_sel_o, .tx_line_timing_sel_o, .analog_loop_o,
        .line_loop_o, .payload_loop_o, .diagnostic_loop_o, .alarm_i,
        .first_pin_out_en_i, .second_pin_out_en_i, .first_general_pin_o,
        .first_general_pin_oe_o, .second_general_pin_o,
        .second_general_pin_oe_o, .tx_pin_core_i, .tx_pin_o
    );

    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // bounded wait for hready sampled high at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge clk_i);
        while (hreadyout_o !== 1'b1 && n < 64)
        begin
            @(posedge clk_i);
            n++;
        end
        chk("bus ready", 32'h0000_0001, 32'(hreadyout_o));
        if (hreadyout_o !== 1'b1)
            end_of_test();
    endtask

    task automatic ahb(input logic [31:0] a, input logic w,
                       input logic [31:0] d, input logic [2:0] sz);
        @(posedge clk_i);
        hsel_i <= 1'b1;
        haddr_i <= a;
        hwrite_i <= w;
        hsize_i <= sz;
        htrans_i <= 2'h2;
        wait_ready();
        htrans_i <= 2'h0;
        hwdata_i <= d;
        wait_ready();
        rd = hrdata_o;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        ahb(a, 1'b1, d, 3'h2);
    endtask

    task automatic rdchk(input string nm, input logic [31:0] a,
                         input logic [31:0] e);
        ahb(a, 1'b0, 32'h0000_0000, 3'h2);
        chk(nm, e, rd);
    endtask

    // outputs trail the register by one edge; three edges leave margin
    task automatic settle();
        repeat (3) @(posedge clk_i);
        #1;
    endtask

    task automatic t_reset();
        wr(ADDR_LOOP_ALARM, 32'h0000_07FF);
        wr(ADDR_TX_INV, 32'h0000_17FF);
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        #1;
        chk("src", 32'(TXC_RATE_ADAPTER), 32'(tx_clk_src_o));
        chk("diag", 32'h0000_0000, 32'(diagnostic_loop_o));
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rdchk("timing reg", ADDR_CLK_TIMING, 32'h0000_0000);
        rdchk("loop reg", ADDR_LOOP_ALARM, 32'h0000_0000);
        rdchk("inv reg", ADDR_TX_INV, 32'h0000_0000);
        $display("done reset");
    endtask

    task automatic t_regs();
        wr(ADDR_CLK_TIMING, 32'hFFFF_FFFF);
        wr(ADDR_LOOP_ALARM, 32'hFFFF_FFFF);
        wr(ADDR_TX_INV, 32'hFFFF_FFFF);
        wr(32'h0000_0100, 32'hFFFF_FFFF);
        // a byte-sized write must be dropped
        ahb(ADDR_CLK_TIMING, 1'b1, 32'h0000_0000, 3'h0);
        rdchk("timing", ADDR_CLK_TIMING, 32'(MASK_CLK_TIMING));
        rdchk("loop", ADDR_LOOP_ALARM, 32'h0000_07FF);
        rdchk("inv", ADDR_TX_INV, 32'h0000_17FF);
        rdchk("unmapped", 32'h0000_0100, 32'h0000_0000);
        chk("hresp", 32'h0000_0000, 32'(hresp_o));
        $display("done registers");
    endtask

    task automatic t_ref();
        logic e;
        logic t;
        for (int c = 0; c < 8; c++)
        begin
            wr(ADDR_CLK_TIMING, (32'(c) << 5) | 32'(c & 7));
            for (int p = 0; p < 2; p++)
            begin
                e = c[2] ? (c[1] ? ~p[0] : p[0]) : 1'b0;
                t = c[0] ? e : ~e;
                @(posedge clk_i);
                rx_framer_ref_8k_i <= p[0];
                tx_framer_ref_8k_i <= ~p[0];
                global_ref_8k_i <= ~e;
                settle();
                chk("port ref", 32'(e), 32'(port_ref_o));
                chk("timer", 32'(t), 32'(second_timer_ref_o));
                chk("a", 32'(c[0]), 32'(tx_line_timing_sel_o));
                chk("b", 32'(c[1]), 32'(tx_framer_timing_sel_o));
                chk("c", 32'(c[2]), 32'(rx_framer_timing_sel_o));
            end
        end
        $display("done reference");
    endtask

    task automatic t_txclk();
        logic [7:0] cr [8] = '{8'h10, 8'h18, 8'h00, 8'h08, 8'h08, 8'h08,
                               8'h08, 8'h00};
        logic [2:0] lb [8] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h4, 3'h1};
        pcla_tx_clk_src_t sr [8] = '{TXC_RX, TXC_RX, TXC_RATE_ADAPTER,
            TXC_PIN, TXC_PIN, TXC_RX, TXC_RX, TXC_RATE_ADAPTER};
        logic e;
        for (int k = 0; k < 8; k++)
        begin
            wr(ADDR_CLK_TIMING, 32'(cr[k]));
            wr(ADDR_LOOP_ALARM, 32'(lb[k]) << 8);
            wr(ADDR_TX_INV, 32'(k == 4));
            for (int p = 0; p < 3; p++)
            begin
                @(posedge clk_i);
                rx_clk_i <= (p == 0);
                rate_adapter_clk_i <= (p == 1);
                tx_pin_core_i <= 16'(p == 2);
                settle();
                e = (p == 2) ^ (k == 4);
                if (sr[k] == TXC_RX)
                    e = (p == 0);
                if (sr[k] == TXC_RATE_ADAPTER)
                    e = (p == 1);
                chk("src", 32'(sr[k]), 32'(tx_clk_src_o));
                chk("tx clk", 32'(e), 32'(tx_clk_o));
            end
        end
        $display("done tx clock");
    endtask

    task automatic t_loop();
        for (int c = 0; c < 8; c++)
        begin
            wr(ADDR_LOOP_ALARM, 32'(c) << 8);
            settle();
            chk("analog", 32'(c == 1), 32'(analog_loop_o));
            chk("line", 32'(c == 2 || c == 6), 32'(line_loop_o));
            chk("payload", 32'(c == 3), 32'(payload_loop_o));
            chk("diag", 32'(c >= 4), 32'(diagnostic_loop_o));
        end
        $display("done loopback");
    endtask

    function automatic logic alm(input logic [3:0] c, input logic [5:0] a);
        if (c < 4'h6)
            return a[c];
        if (c == 4'hB || c == 4'hD)
            return a[ALM_LOS] | a[ALM_LOF] | a[ALM_AIS];
        if (c == 4'hE)
            return a[ALM_RAI] | a[ALM_IDLE];
        return (c == 4'hF) ? |a : 1'b0;
    endfunction

    task automatic t_alarm();
        logic [5:0] a;
        for (int c = 0; c < 16; c++)
        begin
            wr(ADDR_LOOP_ALARM, (32'(15 - c) << 4) | 32'(c));
            for (int k = 0; k < 7; k++)
            begin
                a = (k < 6) ? 6'(1 << k) : 6'h00;
                @(posedge clk_i);
                alarm_i <= a;
                first_pin_out_en_i <= c[0];
                second_pin_out_en_i <= k[0];
                settle();
                chk("pin a", 32'(alm(4'(c), a)), 32'(first_general_pin_o));
                chk("pin b", 32'(alm(4'(15 - c), a)),
                    32'(second_general_pin_o));
                chk("oe a", 32'(c[0]), 32'(first_general_pin_oe_o));
                chk("oe b", 32'(k[0]), 32'(second_general_pin_oe_o));
            end
        end
        $display("done alarms");
    endtask

    task automatic t_inv();
        logic [15:0] iv [3] = '{16'hFFFF, 16'h0000, 16'h1001};
        logic [15:0] co [3] = '{16'hA5C3, 16'hA5C3, 16'hFFFF};
        for (int k = 0; k < 3; k++)
        begin
            wr(ADDR_TX_INV, 32'(iv[k]));
            rdchk("inv", ADDR_TX_INV, 32'(iv[k] & 16'h17FF));
            @(posedge clk_i);
            tx_pin_core_i <= co[k];
            settle();
            chk("pins", 32'(co[k] ^ (iv[k] & 16'h17FF)), 32'(tx_pin_o));
        end
        $display("done inversion");
    endtask

    initial
    begin
        repeat (100000) @(posedge clk_i);
        fails++;
        end_of_test();
    end

    initial
    begin
        fails = 0;
        tests_run = 0;
        reset_n_i = 1'b0;
        {hsel_i, hwrite_i, htrans_i, hsize_i} = 7'h00;
        haddr_i = 32'h0000_0000;
        hwdata_i = 32'h0000_0000;
        {global_ref_8k_i, rx_framer_ref_8k_i, tx_framer_ref_8k_i} = 3'h0;
        {rx_clk_i, rate_adapter_clk_i} = 2'h0;
        {first_pin_out_en_i, second_pin_out_en_i} = 2'h0;
        alarm_i = 6'h00;
        tx_pin_core_i = 16'h0000;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_regs();
        t_ref();
        t_txclk();
        t_loop();
        t_alarm();
        t_inv();
        end_of_test();
    end
endmodule
